// ===== common/ispl_pkg.sv
package ispl_pkg;
    // AXI4-Lite register byte addresses
    localparam logic [7:0] ADDR_MAIN_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_SECOND_CTRL = 8'h04;
    localparam logic [7:0] ADDR_THIRD_CTRL  = 8'h08;
    localparam logic [7:0] ADDR_PRIO_THREE  = 8'h0C;
    localparam logic [7:0] ADDR_RESET_CAUSE = 8'h10;
    localparam logic [7:0] ADDR_TIMER_LOW   = 8'h14;
    localparam logic [7:0] ADDR_TIMER_HIGH  = 8'h18;
    localparam logic [7:0] ADDR_TIMER_CFG   = 8'h1C;
    localparam logic [7:0] ADDR_STATUS      = 8'h20;
    localparam logic [7:0] ADDR_PERIPH_REQ  = 8'h24;

    // main_irq_control fields
    localparam int MAIN_GLOBAL_EN   = 7;
    localparam int MAIN_PERIPH_EN   = 6;
    localparam int MAIN_TIMER_EN    = 5;
    localparam int MAIN_PIN0_EN     = 4;
    localparam int MAIN_PORT_EN     = 3;
    localparam int MAIN_TIMER_FLAG  = 2;
    localparam int MAIN_PIN0_FLAG   = 1;
    localparam int MAIN_PORT_FLAG   = 0;
    // second_irq_control fields
    localparam int SECOND_EDGE0     = 6;
    localparam int SECOND_EDGE1     = 5;
    localparam int SECOND_EDGE2     = 4;
    localparam int SECOND_EDGE3     = 3;
    localparam int SECOND_TIMER_LVL = 2;
    localparam int SECOND_PIN3_LVL  = 1;
    localparam int SECOND_PORT_LVL  = 0;
    // third_irq_control fields
    localparam int THIRD_PIN2_LVL   = 7;
    localparam int THIRD_PIN1_LVL   = 6;
    localparam int THIRD_PIN3_EN    = 5;
    localparam int THIRD_PIN2_EN    = 4;
    localparam int THIRD_PIN1_EN    = 3;
    localparam int THIRD_PIN3_FLAG  = 2;
    localparam int THIRD_PIN2_FLAG  = 1;
    localparam int THIRD_PIN1_FLAG  = 0;
    // peripheral_priority_three fields
    localparam int PRIO_RX          = 5;
    localparam int PRIO_TX          = 4;
    localparam int PRIO_CAP3        = 0;
    localparam logic [7:0] PRIO_THREE_MASK = 8'h31;
    localparam logic [7:0] PRIO_THREE_RO   = 8'h30;
    // reset_cause_control fields
    localparam int RC_LEVEL_EN      = 7;
    localparam int RC_SW_BO_EN      = 6;
    localparam int RC_SOFT_RESET    = 4;
    localparam int RC_WATCHDOG      = 3;
    localparam int RC_SLEEP_ENTRY   = 2;
    localparam int RC_POWER_UP      = 1;
    localparam int RC_BROWNOUT      = 0;
    localparam logic [7:0] RESET_CAUSE_MASK = 8'hDF;
    localparam logic [7:0] RESET_CAUSE_RO   = 8'h0C;

    // Values after reset
    localparam logic [7:0] MAIN_RESET       = 8'h00;
    localparam logic [7:0] SECOND_RESET     = 8'h7F;
    localparam logic [7:0] THIRD_RESET      = 8'hC0;
    localparam logic [7:0] PRIO_THREE_RESET = 8'h31;
    localparam logic [7:0] RESET_CAUSE_RST  = 8'h5C;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Requests toward the core
    typedef struct packed {
        logic high_req;
        logic low_req;
        logic wake;
        logic vector_high;
        logic save_ctx;
    } ispl_core_req_t;

    // Context captured at interrupt entry
    typedef struct packed {
        logic [20:0] ret_pc;
        logic [7:0]  working;
        logic [7:0]  status;
        logic [7:0]  bank_sel;
    } ispl_context_t;
endpackage

// ===== core/ispl_core.sv
`timescale 1ns/1ps
// Operation
// - Priority three register: receive at bit 5, transmit bit 4, capture three bit 0.
// - Unused bits of priority three and reset-cause bit 5 read zero.
// - Reset-cause bit 7 enables two levels; clear means single level; resets zero.
// - Reset-cause holds brown-out enable, reset, watchdog, sleep, power-up, brown-out flags.
// - External pins are edge-triggered.
// - Edge-select one picks rising edge, zero picks falling edge.
// - Selected edge sets pin flag; clearing enable blocks its interrupt.
// - Enabled pin interrupt wakes processor from low-power modes.
// - After wake, vector taken only with global enable set.
// - Pins one, two, three priority from their own level bits.
// - Pin zero always high priority.
// - Eight-bit timer roll-over FFh to 00h sets overflow flag.
// - Sixteen-bit mode flags only on FFFFh to 0000h roll-over.
// - Timer interrupt enabled by main bit 5, priority second bit 2.
// - Any change on port pins 7..4 sets port-change flag.
// - Port-change enabled by main bit 3, priority second bit 0.
// - Entry pushes return address and shadows working, status, bank select.
// - Peripheral level bits matter only while level scheme enabled.
module ispl_core
    import ispl_pkg::*;
#(
    parameter int STACK_DEPTH = 31
) (
    // Clock and reset
    input  wire logic                 mclk_in,
    input  wire logic                 reset_in,
    // AXI4-Lite slave
    input  wire logic [7:0]           s_axi_awaddr_in,
    input  wire logic                 s_axi_awvalid_in,
    output logic                      s_axi_awready_out,
    input  wire logic [31:0]          s_axi_wdata_in,
    input  wire logic [3:0]           s_axi_wstrb_in,
    input  wire logic                 s_axi_wvalid_in,
    output logic                      s_axi_wready_out,
    output logic [1:0]                s_axi_bresp_out,
    output logic                      s_axi_bvalid_out,
    input  wire logic                 s_axi_bready_in,
    input  wire logic [7:0]           s_axi_araddr_in,
    input  wire logic                 s_axi_arvalid_in,
    output logic                      s_axi_arready_out,
    output logic [31:0]               s_axi_rdata_out,
    output logic [1:0]                s_axi_rresp_out,
    output logic                      s_axi_rvalid_out,
    input  wire logic                 s_axi_rready_in,
    // Pins
    input  wire logic [3:0]           ext_pin_in,
    input  wire logic [3:0]           port_upper_in,
    // Core side
    input  wire logic                 sleeping_in,
    input  wire logic                 irq_ack_in,
    input  wire logic [20:0]          pc_in,
    input  wire ispl_context_t        ctx_in,
    input  wire logic                 serial_rx_req_in,
    input  wire logic                 serial_tx_req_in,
    input  wire logic                 capture_three_req_in,
    output ispl_core_req_t            core_req_out,
    output ispl_context_t             shadow_out,
    output logic [4:0]                stack_ptr_out
);
    initial begin
        if (STACK_DEPTH < 1 || STACK_DEPTH > 31) $error("STACK_DEPTH out of range");
    end

    logic [7:0]  main_irq_control;
    logic [7:0]  second_irq_control;
    logic [7:0]  third_irq_control;
    logic [7:0]  peripheral_priority_three;
    logic [7:0]  reset_cause_control;
    logic [7:0]  timer_low;
    logic [7:0]  timer_high;
    logic        timer_wide;
    logic [20:0] ret_stack [STACK_DEPTH];

    // Two-stage pin synchronisers
    logic [3:0]  pin_meta, pin_sync, pin_prev;
    logic [3:0]  port_meta, port_sync, port_prev;
    always_ff @(posedge mclk_in) begin
        pin_meta  <= ext_pin_in;
        pin_sync  <= pin_meta;
        port_meta <= port_upper_in;
        port_sync <= port_meta;
        if (reset_in) begin
            pin_prev  <= 4'h0;
            port_prev <= 4'h0;
        end else begin
            pin_prev  <= pin_sync;
            port_prev <= port_sync;
        end
    end

    logic [3:0] edge_sel;
    logic [3:0] pin_event;
    logic       port_event;
    logic [3:0] armed;
    assign edge_sel = {second_irq_control[SECOND_EDGE3], second_irq_control[SECOND_EDGE2],
                       second_irq_control[SECOND_EDGE1], second_irq_control[SECOND_EDGE0]};
    assign pin_event  = armed & ((edge_sel & pin_sync & ~pin_prev)
                      | (~edge_sel & ~pin_sync & pin_prev));
    assign port_event = armed[0] && (port_sync != port_prev);

    // Compare only after the first sampled value, avoiding a false edge at reset
    always_ff @(posedge mclk_in) begin
        if (reset_in) armed <= 4'h0;
        else          armed <= 4'hF;
    end

    // Timer zero
    logic timer_overflow;
    assign timer_overflow = timer_wide ? ({timer_high, timer_low} == 16'hFFFF)
                                       : (timer_low == 8'hFF);

    // AXI write channel
    logic [7:0]  aw_addr;
    logic        aw_held, w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_write;
    logic [7:0]  wbyte;
    assign do_write = aw_held && w_held && !s_axi_bvalid_out;
    assign wbyte    = w_data[7:0];

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            aw_held           <= 1'b0;
            w_held            <= 1'b0;
            aw_addr           <= 8'h00;
            w_data            <= 32'h0000_0000;
            w_strb            <= 4'h0;
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out  <= 1'b0;
            s_axi_bvalid_out  <= 1'b0;
            s_axi_bresp_out   <= RESP_OKAY;
        end else begin
            s_axi_awready_out <= !aw_held && !s_axi_awready_out && !s_axi_bvalid_out;
            s_axi_wready_out  <= !w_held && !s_axi_wready_out && !s_axi_bvalid_out;
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_in;
                s_axi_awready_out <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_in;
                w_strb <= s_axi_wstrb_in;
                s_axi_wready_out <= 1'b0;
            end
            if (do_write) begin
                aw_held          <= 1'b0;
                w_held           <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out  <= (aw_addr <= ADDR_TIMER_CFG && aw_addr[1:0] == 2'h0)
                                    ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
        end
    end

    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] target, input logic [3:0] st);
        wr_hit = (a == target) && st[0];
    endfunction

    // Interrupt entry handshake
    logic entry;
    assign entry = irq_ack_in && (core_req_out.high_req || core_req_out.low_req);

    // Control and flags; hardware set beats software clear
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            main_irq_control   <= MAIN_RESET;
            second_irq_control <= SECOND_RESET;
            third_irq_control  <= THIRD_RESET;
        end else begin
            if (wr_hit(aw_addr, ADDR_MAIN_CTRL, w_strb) && do_write) main_irq_control <= wbyte;
            if (wr_hit(aw_addr, ADDR_SECOND_CTRL, w_strb) && do_write) second_irq_control <= wbyte;
            if (wr_hit(aw_addr, ADDR_THIRD_CTRL, w_strb) && do_write) third_irq_control <= wbyte;
            // flags only set here, cleared only by software write
            if (pin_event[0])  main_irq_control[MAIN_PIN0_FLAG]   <= 1'b1;
            if (timer_overflow) main_irq_control[MAIN_TIMER_FLAG] <= 1'b1;
            if (port_event)    main_irq_control[MAIN_PORT_FLAG]   <= 1'b1;
            if (pin_event[1])  third_irq_control[THIRD_PIN1_FLAG] <= 1'b1;
            if (pin_event[2])  third_irq_control[THIRD_PIN2_FLAG] <= 1'b1;
            if (pin_event[3])  third_irq_control[THIRD_PIN3_FLAG] <= 1'b1;
            // Global enable is dropped by the core on entry
            if (entry) main_irq_control[MAIN_GLOBAL_EN] <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            peripheral_priority_three <= PRIO_THREE_RESET;
            reset_cause_control       <= RESET_CAUSE_RST;
        end else begin
            // Receive and transmit level bits are read-only; only capture three is writable
            if (wr_hit(aw_addr, ADDR_PRIO_THREE, w_strb) && do_write)
                peripheral_priority_three <= (peripheral_priority_three & PRIO_THREE_RO)
                                           | (wbyte & PRIO_THREE_MASK & ~PRIO_THREE_RO);
            // Watchdog and sleep flags are status only; a write must not disturb them
            if (wr_hit(aw_addr, ADDR_RESET_CAUSE, w_strb) && do_write)
                reset_cause_control <= (reset_cause_control & RESET_CAUSE_RO)
                                     | (wbyte & RESET_CAUSE_MASK & ~RESET_CAUSE_RO);
        end
    end

    // Timer counts every clock; software may preload it
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            timer_low  <= 8'h00;
            timer_high <= 8'h00;
            timer_wide <= 1'b0;
        end else begin
            timer_low <= timer_low + 8'h01;
            if (timer_wide && timer_low == 8'hFF) timer_high <= timer_high + 8'h01;
            if (wr_hit(aw_addr, ADDR_TIMER_LOW, w_strb) && do_write) timer_low <= wbyte;
            if (wr_hit(aw_addr, ADDR_TIMER_HIGH, w_strb) && do_write) timer_high <= wbyte;
            if (wr_hit(aw_addr, ADDR_TIMER_CFG, w_strb) && do_write) timer_wide <= wbyte[0];
        end
    end

    // Request routing
    logic levels_on;
    logic [6:0] src_act;
    logic [6:0] src_lvl;
    assign levels_on = reset_cause_control[RC_LEVEL_EN];
    assign src_act = {
        serial_rx_req_in && main_irq_control[MAIN_PERIPH_EN],
        serial_tx_req_in && main_irq_control[MAIN_PERIPH_EN],
        capture_three_req_in && main_irq_control[MAIN_PERIPH_EN],
        main_irq_control[MAIN_TIMER_FLAG] && main_irq_control[MAIN_TIMER_EN],
        main_irq_control[MAIN_PORT_FLAG] && main_irq_control[MAIN_PORT_EN],
        main_irq_control[MAIN_PIN0_FLAG] && main_irq_control[MAIN_PIN0_EN],
        |(third_irq_control[2:0] & third_irq_control[5:3])};
    logic pins_high, pins_low;
    assign pins_high = (third_irq_control[THIRD_PIN1_FLAG] && third_irq_control[THIRD_PIN1_EN]
                        && third_irq_control[THIRD_PIN1_LVL])
                    || (third_irq_control[THIRD_PIN2_FLAG] && third_irq_control[THIRD_PIN2_EN]
                        && third_irq_control[THIRD_PIN2_LVL])
                    || (third_irq_control[THIRD_PIN3_FLAG] && third_irq_control[THIRD_PIN3_EN]
                        && second_irq_control[SECOND_PIN3_LVL]);
    assign pins_low  = src_act[0] && !pins_high;
    assign src_lvl = {peripheral_priority_three[PRIO_RX], peripheral_priority_three[PRIO_TX],
                      peripheral_priority_three[PRIO_CAP3], second_irq_control[SECOND_TIMER_LVL],
                      second_irq_control[SECOND_PORT_LVL], 1'b1, 1'b1};
    logic any_high, any_low, any_pending;
    assign any_high    = |(src_act[6:1] & src_lvl[6:1]) || pins_high;
    assign any_low     = |(src_act[6:1] & ~src_lvl[6:1]) || pins_low;
    assign any_pending = |src_act;
    logic pin_wake;
    assign pin_wake = (main_irq_control[MAIN_PIN0_FLAG] && main_irq_control[MAIN_PIN0_EN])
                    || |(third_irq_control[2:0] & third_irq_control[5:3]);

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            core_req_out <= '0;
        end else begin
            if (levels_on) begin
                core_req_out.high_req <= main_irq_control[MAIN_GLOBAL_EN] && any_high;
                core_req_out.low_req  <= main_irq_control[MAIN_GLOBAL_EN] && any_low && !any_high;
            end else begin
                core_req_out.high_req <= main_irq_control[MAIN_GLOBAL_EN] && any_pending;
                core_req_out.low_req  <= 1'b0;
            end
            core_req_out.wake        <= sleeping_in && (pin_wake || any_pending);
            core_req_out.vector_high <= !levels_on || any_high;
            core_req_out.save_ctx    <= entry;
            if (entry) begin
                core_req_out.high_req <= 1'b0;
                core_req_out.low_req  <= 1'b0;
            end
        end
    end

    // Context save on entry
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            shadow_out    <= '0;
            stack_ptr_out <= 5'h00;
        end else if (entry) begin
            shadow_out.ret_pc   <= pc_in;
            shadow_out.working  <= ctx_in.working;
            shadow_out.status   <= ctx_in.status;
            shadow_out.bank_sel <= ctx_in.bank_sel;
            if (stack_ptr_out < 5'(STACK_DEPTH)) stack_ptr_out <= stack_ptr_out + 5'h01;
        end
    end
    always_ff @(posedge mclk_in) begin
        if (entry && stack_ptr_out < 5'(STACK_DEPTH)) ret_stack[stack_ptr_out] <= pc_in;
    end

    // Read channel
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        unique case (s_axi_araddr_in)
            ADDR_MAIN_CTRL:   rd_byte = main_irq_control;
            ADDR_SECOND_CTRL: rd_byte = second_irq_control;
            ADDR_THIRD_CTRL:  rd_byte = third_irq_control;
            ADDR_PRIO_THREE:  rd_byte = peripheral_priority_three & PRIO_THREE_MASK;
            ADDR_RESET_CAUSE: rd_byte = reset_cause_control & RESET_CAUSE_MASK;
            ADDR_TIMER_LOW:   rd_byte = timer_low;
            ADDR_TIMER_HIGH:  rd_byte = timer_high;
            ADDR_TIMER_CFG:   rd_byte = {7'h00, timer_wide};
            ADDR_STATUS:      rd_byte = {5'h00, core_req_out.wake, core_req_out.low_req, core_req_out.high_req};
            ADDR_PERIPH_REQ:  rd_byte = {5'h00, src_act[6:4]};
            default:          rd_byte = 8'h00;
        endcase
    end
    logic rd_ok;
    assign rd_ok = s_axi_araddr_in <= ADDR_PERIPH_REQ && s_axi_araddr_in[1:0] == 2'h0;

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h0000_0000;
            s_axi_rresp_out   <= RESP_OKAY;
        end else begin
            s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out && s_axi_arvalid_in;
            if (s_axi_arvalid_in && s_axi_arready_out) begin
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out  <= {24'h000000, rd_byte};
                s_axi_rresp_out  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid_out && s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end
        end
    end

    // Checks
    main_flag_set_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        pin_event[0] |=> main_irq_control[MAIN_PIN0_FLAG]) else $error("pin zero flag not set");
    timer8_ovf_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        (!timer_wide && timer_low == 8'hFF) |=> main_irq_control[MAIN_TIMER_FLAG])
        else $error("timer overflow flag missed");
    timer16_no_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        (timer_wide && timer_high != 8'hFF && !main_irq_control[MAIN_TIMER_FLAG] && !do_write)
        |=> !main_irq_control[MAIN_TIMER_FLAG]) else $error("wide timer flag early");
    port_change_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        port_event |=> main_irq_control[MAIN_PORT_FLAG]) else $error("port change missed");
    prio_unused_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        (peripheral_priority_three & ~PRIO_THREE_MASK) == 8'h00) else $error("unused bits set");
    single_level_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        !levels_on |=> !core_req_out.low_req) else $error("low request in single level");
    pin0_high_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        (levels_on && main_irq_control[MAIN_GLOBAL_EN] && src_act[1] && !entry)
        |=> core_req_out.high_req) else $error("pin zero not high");
    no_gie_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        !main_irq_control[MAIN_GLOBAL_EN] |=> !core_req_out.high_req && !core_req_out.low_req)
        else $error("request without global enable");
    save_ctx_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        entry |=> core_req_out.save_ctx && shadow_out.ret_pc == $past(pc_in))
        else $error("context not saved");
    wake_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        (sleeping_in && pin_wake) |=> core_req_out.wake) else $error("no wake");
    // Status-only fields survive any register write
    prio_readonly_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        $stable(peripheral_priority_three & PRIO_THREE_RO))
        else $error("priority read-only bits changed");
    rc_readonly_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        $stable(reset_cause_control & RESET_CAUSE_RO))
        else $error("reset-cause status bits changed");
    stack_push_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        (entry && stack_ptr_out < 5'(STACK_DEPTH))
        |=> ret_stack[$past(stack_ptr_out)] == $past(pc_in))
        else $error("return address not pushed");
endmodule // ispl_core

// ===== tb/ispl_core_model.sv
`timescale 1ns/1ps
module ispl_core_model
    import ispl_pkg::*;
(
    // Clock and reset
    input  wire logic            mclk_in,
    input  wire logic            reset_in,
    // Bench control and requests
    input  wire logic            take_in,
    input  wire ispl_core_req_t  core_req_in,
    // Core outputs
    output logic                 irq_ack_out,
    output logic [20:0]          pc_out,
    output ispl_context_t        ctx_out
);
    logic done;
    // One entry per take window, so a lingering request is not taken twice
    always_ff @(posedge mclk_in) begin
        if (reset_in || !take_in) begin
            irq_ack_out <= 1'b0;
            done        <= 1'b0;
        end else begin
            irq_ack_out <= !done && (core_req_in.high_req || core_req_in.low_req);
            done        <= done || core_req_in.high_req || core_req_in.low_req;
        end
    end
    assign pc_out  = 21'h1A2B3;
    assign ctx_out = '{ret_pc: 21'h0, working: 8'h5A, status: 8'hC3, bank_sel: 8'h0F};
endmodule // ispl_core_model

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import ispl_pkg::*;
    logic           clk, rst, awv, wv, br, arv, rr, awr, wrd, bv, arr, rv, slp, tk, ack, cap;
    logic [7:0]     aw, ar;
    logic [31:0]    wd, rd;
    logic [1:0]     bresp, rresp, rs;
    logic [3:0]     pin, prt;
    logic [20:0]    pc;
    logic [4:0]     sp;
    ispl_context_t  ctx, sh;
    ispl_core_req_t q;
    int             n_fail, n_checks;
    ispl_core i_ispl_core (.mclk_in(clk), .reset_in(rst), .s_axi_awaddr_in(aw), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wrd), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
        .s_axi_araddr_in(ar), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rd),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .ext_pin_in(pin),
        .port_upper_in(prt), .sleeping_in(slp), .irq_ack_in(ack), .pc_in(pc), .ctx_in(ctx),
        .serial_rx_req_in(1'b0), .serial_tx_req_in(1'b0), .capture_three_req_in(cap),
        .core_req_out(q), .shadow_out(sh), .stack_ptr_out(sp));
    ispl_core_model i_ispl_core_model (.mclk_in(clk), .reset_in(rst), .take_in(tk), .core_req_in(q),
        .irq_ack_out(ack), .pc_out(pc), .ctx_out(ctx));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
        n_checks++;
        if (v !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", s, e, v);
        end
    endtask
    task automatic w(input logic [7:0] a, input logic [7:0] v);
        logic ad, wdn;
        ad  = 1'b0;
        wdn = 1'b0;
        aw  <= a;
        wd  <= {24'h0, v};
        awv <= 1'b1;
        wv  <= 1'b1;
        br  <= 1'b1;
        while (!(ad && wdn)) begin
            @(posedge clk);
            if (!ad && awr) begin
                awv <= 1'b0;
                ad = 1'b1;
            end
            if (!wdn && wrd) begin
                wv  <= 1'b0;
                wdn = 1'b1;
            end
        end
        while (!bv) @(posedge clk);
        chk("bresp", RESP_OKAY, bresp);
        br <= 1'b0;
        @(posedge clk);
    endtask
    task automatic r(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m, input string s);
        ar  <= a;
        arv <= 1'b1;
        rr  <= 1'b1;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        while (!rv) @(posedge clk);
        rr <= 1'b0;
        rs = rresp;
        chk(s, {24'h0, e}, rd & {24'h0, m});
        @(posedge clk);
    endtask
    task automatic t_regs;
        r(ADDR_PRIO_THREE, 8'h31, 8'hFF, "prio3");
        r(ADDR_RESET_CAUSE, 8'h5C, 8'hFF, "rcause");
        w(ADDR_PRIO_THREE, 8'h00);
        r(ADDR_PRIO_THREE, 8'h30, 8'hFF, "prio3");
        w(ADDR_PRIO_THREE, 8'hFF);
        r(ADDR_PRIO_THREE, 8'h31, 8'hFF, "prio3");
        w(ADDR_RESET_CAUSE, 8'hFF);
        r(ADDR_RESET_CAUSE, 8'hDF, 8'hFF, "rcause");
        w(ADDR_RESET_CAUSE, 8'h00);
        r(ADDR_RESET_CAUSE, 8'h0C, 8'hFF, "rcause");
        r(8'h40, 8'h00, 8'hFF, "unmapped");
        chk("rresp", RESP_SLVERR, rs);
    endtask
    task automatic t_pins;
        w(ADDR_MAIN_CTRL, 8'h90);
        pin <= 4'b0011;
        repeat (5) @(posedge clk);
        chk("high_req", 1'b1, q.high_req);
        r(ADDR_MAIN_CTRL, 8'h92, 8'hFF, "main");
        w(ADDR_MAIN_CTRL, 8'h90);
        r(ADDR_MAIN_CTRL, 8'h90, 8'hFF, "main");
        w(ADDR_SECOND_CTRL, 8'h5F);
        pin <= 4'b0001;
        repeat (5) @(posedge clk);
        chk("high_req", 1'b0, q.high_req);
        r(ADDR_THIRD_CTRL, 8'hC1, 8'hFF, "third");
    endtask
    task automatic t_level;
        w(ADDR_MAIN_CTRL, 8'hD0);
        w(ADDR_RESET_CAUSE, 8'h80);
        w(ADDR_THIRD_CTRL, 8'h09);
        repeat (2) @(posedge clk);
        chk("low_req", 1'b1, q.low_req);
        chk("vector_high", 1'b0, q.vector_high);
        w(ADDR_RESET_CAUSE, 8'h00);
        repeat (2) @(posedge clk);
        chk("high_req", 1'b1, q.high_req);
    endtask
    task automatic t_entry;
        slp <= 1'b1;
        repeat (2) @(posedge clk);
        chk("wake", 1'b1, q.wake);
        tk <= 1'b1;
        do @(posedge clk); while (!q.save_ctx);
        chk("shadow", 24'h5AC30F, {sh.working, sh.status, sh.bank_sel});
        chk("ret_pc", 21'h1A2B3, sh.ret_pc);
        chk("stack", 5'h01, sp);
        slp <= 1'b0;
        tk  <= 1'b0;
        @(posedge clk);
    endtask
    task automatic t_events;
        w(ADDR_MAIN_CTRL, 8'h28);
        repeat (300) @(posedge clk);
        r(ADDR_MAIN_CTRL, 8'h04, 8'h04, "tmr_flag");
        prt <= 4'h5;
        repeat (5) @(posedge clk);
        r(ADDR_MAIN_CTRL, 8'h01, 8'h01, "port_flag");
        w(ADDR_TIMER_CFG, 8'h01);
        w(ADDR_MAIN_CTRL, 8'h28);
        repeat (300) @(posedge clk);
        r(ADDR_MAIN_CTRL, 8'h00, 8'h04, "tmr16_flag");
        w(ADDR_TIMER_HIGH, 8'hFF);
        repeat (300) @(posedge clk);
        r(ADDR_MAIN_CTRL, 8'h04, 8'h04, "tmr16_flag");
    endtask
    task automatic t_periph;
        w(ADDR_THIRD_CTRL, 8'h00);
        w(ADDR_PRIO_THREE, 8'h00);
        w(ADDR_RESET_CAUSE, 8'h80);
        w(ADDR_MAIN_CTRL, 8'hC0);
        cap <= 1'b1;
        repeat (2) @(posedge clk);
        chk("low_req", 1'b1, q.low_req);
        chk("high_req", 1'b0, q.high_req);
        r(ADDR_PERIPH_REQ, 8'h01, 8'hFF, "periph");
        w(ADDR_RESET_CAUSE, 8'h00);
        repeat (2) @(posedge clk);
        chk("high_req", 1'b1, q.high_req);
        chk("low_req", 1'b0, q.low_req);
        cap <= 1'b0;
    endtask
    task automatic final_report;
        if (n_fail == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        {awv, wv, br, arv, rr, slp, tk, cap} = '0;
        {aw, ar, wd, prt} = '0;
        pin = 4'b0010;
        n_fail = 0;
        n_checks = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs;
        t_pins;
        t_level;
        t_entry;
        t_events;
        t_periph;
        final_report;
    end
    // Whole run needs well under 2000 cycles
    initial begin
        #200us;
        n_fail++;
        final_report;
    end
endmodule // testbench
